// file: inc/diag_frame_pkg.sv
// Constants and types for the slave diagnostic frame builder
package diag_frame_pkg;
	localparam logic [7:0] NO_MASTER_ADDR = 8'hFF;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [15:0] MAKER_CODE_DEFAULT = 16'h1234; // Arbitrary neutral value
	localparam int STATION_STAT3_IDX = 2;
	localparam int MASTER_ADDR_IDX = 3;
	localparam int MAKER_HI_IDX = 4;
	localparam int MAKER_LO_IDX = 5;
	localparam int HEADER_LEN = 6;
	localparam int MOD_DIAG_MAX = 5;
	localparam int MOD_STAT_MAX = 13;
	localparam int INT_STAT_MAX = 20;
	localparam int INT_HDR_LEN = 4;
	localparam int INT_PROC_INFO_LEN = 4;
	localparam int INT_DIAG_INFO_LEN = 16;
	localparam int INT_DIAG_LIVE_LEN = 4;
	localparam int OVERFLOW_BIT = 7;
	localparam int PRESENT_BIT = 2;
	localparam logic [7:0] INT_CODE_DIAG = 8'h01;
	localparam logic [7:0] INT_CODE_PROC = 8'h02;
	localparam int REC_GEN_LEN = 4;
	localparam int REC_SPEC_MAX = 40;
	localparam int REC_TOTAL_MAX = 44;
	localparam int REC1_MIN_LEN = 12;
	localparam int CHAN_BLOCK_LEN = 4;
	localparam int CHAN_HDR_LEN = 4;
	localparam int CHAN_MAX = 8;
	localparam logic [3:0] CLASS_ANALOG = 4'b0101;
	localparam logic [3:0] CLASS_PROCESSOR = 4'b0110;
	localparam logic [3:0] CLASS_FUNCTION = 4'b1000;
	localparam logic [3:0] CLASS_LIM_DIGITAL = 4'b1001;
	localparam logic [3:0] CLASS_COMM_PROC = 4'b1100;
	localparam logic [3:0] CLASS_POWER = 4'b1101;
	localparam logic [3:0] CLASS_NONE = 4'b0000;
	localparam logic [5:0] FRAME_LEN_MAX = 6'd63;
	localparam int INT_CNT = 4;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	typedef enum logic [1:0] {INT_NONE, INT_PROC, INT_DIAG} int_kind_t;
endpackage

// file: core/diag_frame.sv
// Slave diagnostic frame builder, module records and event flags
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/10ps
// What this block does
// RULE1 - Station status three bits 0-6 zero
// RULE2 - Bit 7 set on message buffer overflow
// RULE3 - Master address byte, FF if unparameterized
// RULE4 - Maker code in bytes 4, 5
// RULE5 - Module diagnosis marks areas with entries
// RULE6 - Module status follows, at most 13
// RULE7 - Interrupt status at y, max 20
// RULE8 - Process interrupt: code 02, info at y+4
// RULE9 - Diagnostic interrupt: code 01, 16 bytes
// RULE10 - Module diagnostics at most 44 bytes
// RULE11 - Record 0 four bytes, record 1 repeats
// RULE12 - Record 1 sized by channels, min 12
// RULE13 - Error bits set to one
// RULE14 - Module class codes in byte 1
// RULE15 - Presence bit set in station status
// RULE16 - Serialize ascending from byte 0
module diag_frame #(
	parameter logic [15:0] MAKER_CODE = diag_frame_pkg::MAKER_CODE_DEFAULT
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic [4:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic DIAG_REQ,
	output logic DIAG_VALID,
	output logic [7:0] DIAG_BYTE,
	output logic DIAG_LAST,
	input wire logic MSG_ARRIVE,
	input wire logic MSG_DRAIN,
	input wire logic REC_REQ,
	input wire logic REC_SEL,
	output logic REC_VALID,
	output logic [7:0] REC_BYTE,
	output logic REC_LAST,
	output logic IRQ
);
	// Register indexes (word per register)
	localparam logic [4:0] A_CTRL = 5'h00;
	localparam logic [4:0] A_MASTER = 5'h01;
	localparam logic [4:0] A_AREAS = 5'h02;
	localparam logic [4:0] A_MODDIAG = 5'h03;
	localparam logic [4:0] A_INTREQ = 5'h04;
	localparam logic [4:0] A_INTINFO = 5'h05;
	localparam logic [4:0] A_MODGEN = 5'h06;
	localparam logic [4:0] A_MODCLS = 5'h07;
	localparam logic [4:0] A_CHAN = 5'h08;
	localparam logic [4:0] A_STAT = 5'h09;
	localparam logic [4:0] A_MASK = 5'h0A;
	localparam logic [4:0] A_FAULT = 5'h10;
	localparam logic [4:0] A_MODST0 = 5'h18;
	localparam logic [7:0] BUF_DEPTH = 8'h04;

	logic [7:0] master_ff, nxt_master;
	logic [3:0] areas_ff;
	logic [31:0] moddiag_ff;
	logic [7:0] modst_ff [0:diag_frame_pkg::MOD_STAT_MAX-1];
	diag_frame_pkg::int_kind_t int_kind_ff;
	logic [31:0] int_info_ff;
	logic [7:0] int_area_ff;
	logic [7:0] gen_ff [0:3];
	logic [3:0] class_ff;
	logic [3:0] nchan_ff;
	logic [7:0] chan_type_ff;
	logic [31:0] fault_ff [0:diag_frame_pkg::CHAN_MAX-1];
	logic [7:0] msg_cnt_ff;
	logic overflow_ff;
	logic [3:0] stat_ff, mask_ff;
	logic [5:0] pos_ff;
	logic busy_ff;
	logic [5:0] rpos_ff;
	logic rbusy_ff, rsel_ff;
	logic [2:0] mdlen, mslen;
	logic [5:0] int_len, frame_len, rec_len;
	logic [3:0] ev;

	// Legal class codes only, else reported as none
	function automatic logic [3:0] legal_class(input logic [3:0] c);
		unique case (c)
			diag_frame_pkg::CLASS_ANALOG, diag_frame_pkg::CLASS_PROCESSOR,
			diag_frame_pkg::CLASS_FUNCTION, diag_frame_pkg::CLASS_LIM_DIGITAL,
			diag_frame_pkg::CLASS_COMM_PROC, diag_frame_pkg::CLASS_POWER: return c;
			default: return diag_frame_pkg::CLASS_NONE;
		endcase
	endfunction

	// Byte of a 32-bit word, LSB first
	function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] i);
		return w[8*i +: 8];
	endfunction

	// Lengths of variable areas
	always_comb begin
		mdlen = 3'(1 + ({1'b0, areas_ff} >> 3)); // RULE5
		mslen = 3'(({1'b0, areas_ff} + 5'd3) >> 2); // RULE6
		unique case (int_kind_ff)
			diag_frame_pkg::INT_PROC: int_len = 6'(diag_frame_pkg::INT_HDR_LEN
				+ diag_frame_pkg::INT_PROC_INFO_LEN); // RULE7
			diag_frame_pkg::INT_DIAG: int_len = 6'(diag_frame_pkg::INT_HDR_LEN
				+ diag_frame_pkg::INT_DIAG_INFO_LEN); // RULE7
			default: int_len = 6'd0;
		endcase
		frame_len = 6'(diag_frame_pkg::HEADER_LEN) + 6'(mdlen) + 6'(mslen) + int_len;
		rec_len = rsel_ff ? 6'(diag_frame_pkg::REC_GEN_LEN + diag_frame_pkg::CHAN_HDR_LEN
			+ diag_frame_pkg::CHAN_BLOCK_LEN * nchan_ff)
			: 6'(diag_frame_pkg::REC_GEN_LEN); // RULE11 RULE12
	end

	// Software writes
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			master_ff <= diag_frame_pkg::NO_MASTER_ADDR;
			areas_ff <= 4'h0;
			moddiag_ff <= 32'h0000_0000;
			int_kind_ff <= diag_frame_pkg::INT_NONE;
			int_info_ff <= 32'h0000_0000;
			int_area_ff <= 8'h00;
			class_ff <= diag_frame_pkg::CLASS_NONE;
			nchan_ff <= 4'h1;
			chan_type_ff <= 8'h00;
			mask_ff <= diag_frame_pkg::IRQ_RESET;
			for (int i = 0; i < 4; i++) begin
				gen_ff[i] <= 8'h00;
			end
			for (int i = 0; i < diag_frame_pkg::MOD_STAT_MAX; i++) begin
				modst_ff[i] <= 8'h00;
			end
			for (int i = 0; i < diag_frame_pkg::CHAN_MAX; i++) begin
				fault_ff[i] <= 32'h0000_0000;
			end
		end else if (REG_WR) begin
			unique case (REG_ADDR)
				A_MASTER: master_ff <= nxt_master; // RULE3
				A_AREAS: areas_ff <= (REG_WDATA[3:0] > 4'd12) ? 4'd12 : REG_WDATA[3:0];
				A_MODDIAG: moddiag_ff <= REG_WDATA; // RULE5
				A_INTREQ: begin
					int_kind_ff <= REG_WDATA[1:0] == 2'd1 ? diag_frame_pkg::INT_PROC
						: REG_WDATA[1:0] == 2'd2 ? diag_frame_pkg::INT_DIAG
						: diag_frame_pkg::INT_NONE;
					int_area_ff <= REG_WDATA[15:8];
				end
				A_INTINFO: int_info_ff <= REG_WDATA;
				A_MODGEN: begin
					for (int i = 0; i < 4; i++) begin
						gen_ff[i] <= REG_WDATA[8*i +: 8]; // RULE13
					end
				end
				A_MODCLS: class_ff <= legal_class(REG_WDATA[3:0]); // RULE14
				A_CHAN: begin
					nchan_ff <= (REG_WDATA[3:0] == 4'd0) ? 4'd1
						: (REG_WDATA[3:0] > 4'd8) ? 4'd8 : REG_WDATA[3:0]; // RULE10 RULE12
					chan_type_ff <= REG_WDATA[15:8];
				end
				A_MASK: mask_ff <= REG_WDATA[3:0];
				default: begin
					if (REG_ADDR[4:3] == A_FAULT[4:3]) begin
						fault_ff[REG_ADDR[2:0]] <= REG_WDATA; // RULE13
					// Six bits so the upper bound does not wrap
					end else if (REG_ADDR >= A_MODST0
						&& 6'(REG_ADDR) < 6'(A_MODST0) + 6'(diag_frame_pkg::MOD_STAT_MAX)) begin
						modst_ff[4'(REG_ADDR - A_MODST0)] <= REG_WDATA[7:0]; // RULE6
					end
				end
			endcase
		end
	end

	always_comb begin
		nxt_master = (REG_WDATA[8]) ? REG_WDATA[7:0] : diag_frame_pkg::NO_MASTER_ADDR; // RULE3
	end

	// Message buffer occupancy and overflow
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			msg_cnt_ff <= 8'h00;
			overflow_ff <= 1'b0;
		end else begin
			if (MSG_ARRIVE && !MSG_DRAIN && msg_cnt_ff == BUF_DEPTH) begin
				overflow_ff <= 1'b1; // RULE2
			end else if (REG_WR && REG_ADDR == A_CTRL && REG_WDATA[0]) begin
				overflow_ff <= 1'b0;
			end
			if (MSG_ARRIVE && !MSG_DRAIN && msg_cnt_ff != BUF_DEPTH) begin
				msg_cnt_ff <= msg_cnt_ff + 8'h01;
			end else if (MSG_DRAIN && !MSG_ARRIVE && msg_cnt_ff != 8'h00) begin
				msg_cnt_ff <= msg_cnt_ff - 8'h01;
			end
		end
	end

	// Events: overflow, frame done, record done, interrupt posted
	always_comb begin
		ev[0] = MSG_ARRIVE && !MSG_DRAIN && msg_cnt_ff == BUF_DEPTH;
		ev[1] = busy_ff && DIAG_LAST;
		ev[2] = rbusy_ff && REC_LAST;
		ev[3] = REG_WR && REG_ADDR == A_INTREQ && REG_WDATA[1:0] != 2'd0;
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			stat_ff <= diag_frame_pkg::IRQ_RESET;
		end else begin
			stat_ff <= (stat_ff & ~((REG_WR && REG_ADDR == A_STAT) ? REG_WDATA[3:0] : 4'h0))
				| ev;
		end
	end

	assign IRQ = |(stat_ff & mask_ff);

	// Frame byte at position p
	function automatic logic [7:0] frame_byte(input logic [5:0] p);
		logic [5:0] x, y, k;
		x = 6'(diag_frame_pkg::HEADER_LEN) + 6'(mdlen);
		y = x + 6'(mslen);
		k = p - y;
		if (p == 6'd0) return 8'h00;
		if (p == 6'd1) return 8'(1 << diag_frame_pkg::PRESENT_BIT); // RULE15
		if (p == 6'(diag_frame_pkg::STATION_STAT3_IDX))
			return {overflow_ff, 7'b000_0000}; // RULE1 RULE2
		if (p == 6'(diag_frame_pkg::MASTER_ADDR_IDX)) return master_ff; // RULE3
		if (p == 6'(diag_frame_pkg::MAKER_HI_IDX)) return MAKER_CODE[15:8]; // RULE4
		if (p == 6'(diag_frame_pkg::MAKER_LO_IDX)) return MAKER_CODE[7:0]; // RULE4
		if (p < x) begin
			if (p == 6'(diag_frame_pkg::HEADER_LEN)) return {2'b01, 6'(mdlen)};
			return word_byte(moddiag_ff, 2'(p - 6'(diag_frame_pkg::HEADER_LEN + 1))); // RULE5
		end
		if (p < y) return modst_ff[4'(p - x)]; // RULE6
		if (k == 6'd0) return 8'(int_len);
		if (k == 6'd1) return (int_kind_ff == diag_frame_pkg::INT_PROC)
			? diag_frame_pkg::INT_CODE_PROC : diag_frame_pkg::INT_CODE_DIAG; // RULE8 RULE9
		if (k == 6'd2) return int_area_ff;
		if (k == 6'd3) return 8'h00;
		if (k < 6'(diag_frame_pkg::INT_HDR_LEN + diag_frame_pkg::INT_DIAG_LIVE_LEN))
			return word_byte(int_info_ff, 2'(k)); // RULE8 RULE9
		return diag_frame_pkg::ZERO_BYTE; // RULE9
	endfunction

	// Record byte at position p
	function automatic logic [7:0] rec_byte(input logic [5:0] p);
		logic [7:0] vec;
		vec = 8'h00;
		if (p == 6'd1) return {gen_ff[1][7:4], class_ff}; // RULE14
		if (p < 6'd4) return gen_ff[p[1:0]]; // RULE11
		if (p == 6'd4) return chan_type_ff;
		if (p == 6'd5) return 8'h20;
		if (p == 6'd6) return 8'(nchan_ff);
		if (p == 6'd7) begin
			for (int i = 0; i < diag_frame_pkg::CHAN_MAX; i++) begin
				vec[i] = |fault_ff[i] && (i < nchan_ff); // RULE13
			end
			return vec;
		end
		return word_byte(fault_ff[3'((p - 6'd8) >> 2)], p[1:0]); // RULE12
	endfunction

	// Frame serializer
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			busy_ff <= 1'b0;
			pos_ff <= 6'd0;
			DIAG_BYTE <= 8'h00;
		end else if (!busy_ff) begin
			if (DIAG_REQ) begin
				busy_ff <= 1'b1;
				pos_ff <= 6'd1;
				DIAG_BYTE <= frame_byte(6'd0); // RULE16
			end
		end else begin
			if (pos_ff == frame_len) begin
				busy_ff <= 1'b0;
			end else begin
				DIAG_BYTE <= frame_byte(pos_ff); // RULE16
				pos_ff <= pos_ff + 6'd1;
			end
		end
	end

	assign DIAG_VALID = busy_ff;
	assign DIAG_LAST = busy_ff && pos_ff == frame_len;

	// Record serializer
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rbusy_ff <= 1'b0;
			rsel_ff <= 1'b0;
			rpos_ff <= 6'd0;
			REC_BYTE <= 8'h00;
		end else if (!rbusy_ff) begin
			if (REC_REQ) begin
				rbusy_ff <= 1'b1;
				rsel_ff <= REC_SEL;
				rpos_ff <= 6'd1;
				REC_BYTE <= rec_byte(6'd0);
			end
		end else begin
			if (rpos_ff == rec_len) begin
				rbusy_ff <= 1'b0;
			end else begin
				REC_BYTE <= rec_byte(rpos_ff);
				rpos_ff <= rpos_ff + 6'd1;
			end
		end
	end

	assign REC_VALID = rbusy_ff;
	assign REC_LAST = rbusy_ff && rpos_ff == rec_len;

	// Register reads
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			REG_RDATA <= 32'h0000_0000;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				A_CTRL: REG_RDATA <= {23'h0, overflow_ff, msg_cnt_ff};
				A_MASTER: REG_RDATA <= {24'h0, master_ff};
				A_AREAS: REG_RDATA <= {28'h0, areas_ff};
				A_MODDIAG: REG_RDATA <= moddiag_ff;
				A_INTREQ: REG_RDATA <= {16'h0, int_area_ff, 6'h0, int_kind_ff};
				A_INTINFO: REG_RDATA <= int_info_ff;
				A_MODCLS: REG_RDATA <= {28'h0, class_ff};
				A_CHAN: REG_RDATA <= {16'h0, chan_type_ff, 4'h0, nchan_ff};
				A_STAT: REG_RDATA <= {28'h0, stat_ff};
				A_MASK: REG_RDATA <= {28'h0, mask_ff};
				default: REG_RDATA <= 32'h0000_0000;
			endcase
		end
	end

	stat_three_a: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE1
		(DIAG_VALID && $past(pos_ff) == 6'd2 && $past(busy_ff))
		|-> DIAG_BYTE[6:0] == 7'h00) else $error("Status three low bits not zero");
	overflow_set_a: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE2
		ev[0] |=> overflow_ff) else $error("Overflow not flagged");
	master_addr_a: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE3
		(REG_WR && REG_ADDR == A_MASTER && !REG_WDATA[8]) |=> master_ff == 8'hFF)
		else $error("Unowned master address not FF");
	frame_start_a: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE16
		(!busy_ff && DIAG_REQ) |=> DIAG_VALID && DIAG_BYTE == 8'h00 && pos_ff == 6'd1)
		else $error("Frame did not start at byte zero");
	frame_len_a: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE6 RULE7
		frame_len <= 6'(diag_frame_pkg::HEADER_LEN + diag_frame_pkg::MOD_DIAG_MAX
		+ diag_frame_pkg::MOD_STAT_MAX + diag_frame_pkg::INT_STAT_MAX))
		else $error("Frame too long");
	rec_len_a: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE10 RULE12
		(rbusy_ff && rsel_ff) |-> rec_len >= 6'(diag_frame_pkg::REC1_MIN_LEN)
		&& rec_len <= 6'(diag_frame_pkg::REC_TOTAL_MAX)) else $error("Record one length");
	rec0_len_a: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE11
		(!rbusy_ff && REC_REQ && !REC_SEL) |-> ##4 REC_LAST) else $error("Record zero length");
	class_code_a: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE14
		$changed(class_ff) |-> class_ff == legal_class(class_ff)) else $error("Bad class");
	status_set_a: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE2
		(ev != 4'h0) |=> (stat_ff & $past(ev)) == $past(ev))
		else $error("Status event lost to clear");
endmodule // diag_frame

// file: tb/diag_reader.sv
// Master-side model that requests one stream and collects its bytes
`timescale 1ns/10ps
module diag_reader (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic go,
	output logic req,
	input wire logic valid,
	input wire logic [7:0] data,
	input wire logic last,
	output logic done,
	output logic [7:0] buf_q [0:63],
	output int cnt
);
	// One-cycle request, then bytes in order until the last one
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			req <= 1'b0;
			done <= 1'b0;
			cnt <= 0;
		end else begin
			req <= go;
			if (go) begin
				done <= 1'b0;
				cnt <= 0;
			end else if (valid && !done) begin
				buf_q[cnt[5:0]] <= data;
				cnt <= cnt + 1;
				done <= last;
			end
		end
	end
endmodule // diag_reader

// file: tb/diag_frame_test.sv
// Self-checking bench for the diagnostic frame builder
`timescale 1ns/10ps
module diag_frame_test;
	localparam logic [15:0] MAKER_TB = 16'h5A3C; // Arbitrary value
	logic MCLK, RSTN, REG_WR, REG_RD, DIAG_VALID, DIAG_LAST, DIAG_REQ, MSG_ARRIVE, MSG_DRAIN;
	logic REC_REQ, REC_SEL, REC_VALID, REC_LAST, IRQ, fgo, rgo, f_done, r_done;
	logic [4:0] REG_ADDR;
	logic [31:0] REG_WDATA, REG_RDATA, v, info, mdg;
	logic [7:0] DIAG_BYTE, REC_BYTE, addr, f_buf [0:63], r_buf [0:63], g [0:3];
	logic [3:0] cls, ch;
	logic [3:0] classes [0:5] = '{diag_frame_pkg::CLASS_ANALOG, diag_frame_pkg::CLASS_PROCESSOR,
		diag_frame_pkg::CLASS_FUNCTION, diag_frame_pkg::CLASS_LIM_DIGITAL,
		diag_frame_pkg::CLASS_COMM_PROC, diag_frame_pkg::CLASS_POWER};
	int f_cnt, r_cnt, err_count, compares, cyc, i, j, y, areas, kind;

	diag_frame #(.MAKER_CODE(MAKER_TB)) u_diag_frame (.MCLK(MCLK), .RSTN(RSTN),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .DIAG_REQ(DIAG_REQ), .DIAG_VALID(DIAG_VALID),
		.DIAG_BYTE(DIAG_BYTE), .DIAG_LAST(DIAG_LAST), .MSG_ARRIVE(MSG_ARRIVE),
		.MSG_DRAIN(MSG_DRAIN), .REC_REQ(REC_REQ), .REC_SEL(REC_SEL), .REC_VALID(REC_VALID),
		.REC_BYTE(REC_BYTE), .REC_LAST(REC_LAST), .IRQ(IRQ));
	diag_reader frame_rd (.mclk(MCLK), .rstn(RSTN), .go(fgo), .req(DIAG_REQ),
		.valid(DIAG_VALID), .data(DIAG_BYTE), .last(DIAG_LAST), .done(f_done),
		.buf_q(f_buf), .cnt(f_cnt));
	diag_reader rec_rd (.mclk(MCLK), .rstn(RSTN), .go(rgo), .req(REC_REQ),
		.valid(REC_VALID), .data(REC_BYTE), .last(REC_LAST), .done(r_done),
		.buf_q(r_buf), .cnt(r_cnt));

	initial begin
		MCLK = 1'b0;
		forever #20 MCLK = ~MCLK;
	end

	// Start of interrupt area: header, module diagnosis, module status
	function automatic int y_of(input int n);
		return 6 + 1 + n / 8 + (n + 3) / 4;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge MCLK);
		REG_WR <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge MCLK);
		REG_RD <= 1'b0;
		#1 v = REG_RDATA;
	endtask

	task automatic msg(input logic drain);
		@(posedge MCLK);
		MSG_ARRIVE <= !drain;
		MSG_DRAIN <= drain;
		@(posedge MCLK);
		MSG_ARRIVE <= 1'b0;
		MSG_DRAIN <= 1'b0;
	endtask

	// k: 0 frame, 1 record 0, 2 record 1
	task automatic run(input int k);
		@(posedge MCLK);
		REC_SEL <= (k == 2);
		fgo <= (k == 0);
		rgo <= (k != 0);
		@(posedge MCLK);
		fgo <= 1'b0;
		rgo <= 1'b0;
		#1;
		for (int n = 0; n < 200 && !(k == 0 ? f_done : r_done); n++) @(posedge MCLK);
		#1 check("stream done", k == 0 ? f_done : r_done, 1'b1);
	endtask

	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end

	initial begin
		{REG_WR, REG_RD, MSG_ARRIVE, MSG_DRAIN, REC_SEL, fgo, rgo, RSTN} = '0;
		REG_ADDR = '0;
		REG_WDATA = '0;
		void'($urandom(18273));
		repeat (4) @(posedge MCLK);
		RSTN <= 1'b1;
		run(0);
		check("stat3", f_buf[2], 8'h00);
		check("present", f_buf[1][diag_frame_pkg::PRESENT_BIT], 1'b1);
		check("master idle", f_buf[3], 8'hFF);
		check("maker hi", f_buf[4], MAKER_TB[15:8]);
		check("maker lo", f_buf[5], MAKER_TB[7:0]);
		check("frame len", f_cnt, y_of(0));
		// Areas, owner, both interrupt kinds
		for (j = 0; j < 3; j++) wr(5'h18 + 5'(j), 32'h0000_00A1 + j);
		for (i = 0; i < 4; i++) begin
			areas = (i == 0) ? 12 : $urandom_range(12, 0);
			addr = 8'($urandom_range(254, 0));
			mdg = $urandom;
			info = $urandom;
			kind = i % 2 + 1;
			wr(5'h02, areas);
			wr(5'h01, {23'h0000_00, i != 3, addr});
			wr(5'h03, mdg);
			wr(5'h05, info);
			wr(5'h04, kind);
			run(0);
			y = y_of(areas);
			check("master", f_buf[3], i != 3 ? addr : 8'hFF);
			check("mod diag len", f_buf[6], 8'h41 + areas / 8);
			if (areas >= 8) check("mod diag", f_buf[7], mdg[7:0]);
			for (j = 0; j < (areas + 3) / 4; j++) begin
				check("mod stat", f_buf[7 + areas / 8 + j], 8'hA1 + j);
			end
			check("int len", f_cnt, y + (kind == 1 ? 8 : 20));
			check("int size", f_buf[y], kind == 1 ? 8 : 20);
			check("int code", f_buf[y + 1], kind == 1 ? 8'h02 : 8'h01);
			for (j = 0; j < 4; j++) check("int info", f_buf[y + 4 + j], info[8 * j +: 8]);
			if (kind == 2) for (j = 8; j < 20; j++) check("int pad", f_buf[y + j], 8'h00);
			wr(5'h04, 32'h0000_0000);
		end
		// Message buffer overflow, masked and unmasked interrupt
		wr(5'h0A, 32'h0000_0000);
		repeat (5) msg(1'b0);
		rd(5'h00);
		check("ctrl ovf", v[8], 1'b1);
		check("irq masked", IRQ, 1'b0);
		wr(5'h0A, 32'h0000_0001);
		@(posedge MCLK);
		#1 check("irq on", IRQ, 1'b1);
		run(0);
		check("stat3 ovf", f_buf[2], 8'h80);
		wr(5'h00, 32'h0000_0001);
		wr(5'h09, 32'h0000_0001);
		@(posedge MCLK);
		#1 check("irq off", IRQ, 1'b0);
		run(0);
		check("stat3 clr", f_buf[2], 8'h00);
		repeat (4) msg(1'b1);
		rd(5'h00);
		check("ctrl drained", v[8:0], 9'h000);
		// Module records, every class code plus an illegal one
		for (i = 0; i < 7; i++) begin
			cls = i < 6 ? classes[i] : 4'b0011;
			ch = 4'($urandom_range(8, 0));
			mdg = $urandom;
			wr(5'h07, cls);
			wr(5'h08, {16'h0000, 8'(i * 16 + 3), 4'h0, ch});
			wr(5'h06, mdg);
			if (i == 6) wr(5'h10, 32'h0000_0001);
			g = '{mdg[7:0], {mdg[15:12], i < 6 ? cls : 4'h0}, mdg[23:16], mdg[31:24]};
			run(1);
			check("rec0 len", r_cnt, 4);
			check("class", r_buf[1][3:0], i < 6 ? cls : 4'h0);
			for (j = 0; j < 4; j++) check("rec0 byte", r_buf[j], g[j]);
			run(2);
			check("rec1 len", r_cnt, 8 + 4 * (ch == 0 ? 1 : ch));
			for (j = 0; j < 4; j++) check("rec1 head", r_buf[j], g[j]);
			check("chan type", r_buf[4], 8'(i * 16 + 3));
			check("chan info", r_buf[5], 8'h20);
			check("chan count", r_buf[6], ch == 0 ? 4'h1 : ch);
			check("fault vec", r_buf[7][0], i == 6);
			check("fault byte", r_buf[8], i == 6);
		end
		tally_and_finish();
	end
endmodule // diag_frame_test
